/* logic/irpc_pkg.sv */
`default_nettype none
package irpc_pkg;
   localparam int CLK_PERIOD_PS     = 8000;
   // Shortest receive pulse accepted, rounded up to whole cycles
   localparam int RX_MIN_PULSE_PS   = 1410000;
   localparam int RX_MIN_CYC        = (RX_MIN_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Nominal carrier phase, 0.8 to 1.2 us allowed
   localparam int CAR_PHASE_PS      = 1000000;
   localparam int CAR_PHASE_CYC     = CAR_PHASE_PS / CLK_PERIOD_PS;
   // Carrier seen as present this long after its last active sample
   localparam int ASK_HOLD_PS       = 4000000;
   localparam int ASK_HOLD_CYC      = ASK_HOLD_PS / CLK_PERIOD_PS;
   // Reference ticks per bit and per transmit pulse (3/16 of a bit)
   localparam int OVERSAMPLE        = 16;
   localparam int TX_PULSE_TICKS    = 3;
   localparam int CFG_RX_POL_BIT    = 0;
   localparam int CFG_TX_POL_BIT    = 1;
   localparam logic [1:0] CFG_RESET = 2'h2;
endpackage
`default_nettype wire

/* logic/irpc_pulse_filter.sv */
`default_nettype none
module irpc_pulse_filter
   import irpc_pkg::*;
#(
   parameter int MIN_CYC = RX_MIN_CYC
) (
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic clk_en,
   input  wire logic level_active,
   output var  logic detect
);
   localparam int CW = $clog2(MIN_CYC + 1);
   logic [CW-1:0] run_q, run_d;
   logic          detect_q, detect_d;

   // One detect per pulse, only once the pulse has lasted MIN_CYC cycles
   always_comb begin
      run_d    = run_q;
      detect_d = 1'b0;
      if (!level_active) begin
         run_d = '0;
      end else if (run_q < CW'(MIN_CYC)) begin
         run_d    = run_q + 1'b1;
         detect_d = (run_q == CW'(MIN_CYC - 1));
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         run_q    <= '0;
         detect_q <= 1'b0;
      end else if (clk_en) begin
         run_q    <= run_d;
         detect_q <= detect_d;
      end
   end

   assign detect = detect_q;

   property p_min_width;
      @(posedge clock) disable iff (rst || !clk_en)
         $rose(detect_q) |-> $past(run_q) == CW'(MIN_CYC - 1);
   endproperty
   a_min_width: assert property (p_min_width) else $error("detect before minimum width");
endmodule
`default_nettype wire

/* logic/irpc_codec.sv */
`default_nettype none
module irpc_codec
   import irpc_pkg::*;
#(
   parameter int TICKS_PER_BIT = OVERSAMPLE,
   parameter int PULSE_TICKS   = TX_PULSE_TICKS
) (
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic clk_en,
   input  wire logic baud_tick,
   input  wire logic ask_mode,
   input  wire logic cfg_rx_active_high,
   input  wire logic cfg_tx_active_high,
   input  wire logic uart_txd,
   output var  logic uart_rxd,
   input  wire logic ir_rx_pin,
   output var  logic ir_tx_pin,
   input  wire logic ask_rx_pin,
   output var  logic ask_tx_pin
);
   localparam int TW = $clog2(TICKS_PER_BIT + 1);
   localparam int CW = $clog2(CAR_PHASE_CYC + 1);
   localparam int HW = $clog2(ASK_HOLD_CYC + 1);

   function automatic logic to_pin(input logic active, input logic high);
      return high ? active : !active;
   endfunction

   logic [1:0]    cfg_q, cfg_d;
   logic          txd_prev_q, txd_prev_d;
   logic [TW-1:0] tx_tick_q, tx_tick_d;
   logic          ir_pulse_q, ir_pulse_d;
   logic [CW-1:0] car_cnt_q, car_cnt_d;
   logic          car_on_q, car_on_d;
   logic          ask_burst_q, ask_burst_d;
   logic [TW-1:0] rx_low_q, rx_low_d;
   logic [HW-1:0] ask_hold_q, ask_hold_d;
   logic          rxd_q, rxd_d;
   logic          ir_tx_q, ir_tx_d;
   logic          ask_tx_q, ask_tx_d;
   logic          ir_rx_active, ask_rx_active, ir_detect;

   // Receive polarity bit serves both schemes
   assign ir_rx_active  = to_pin(ir_rx_pin, cfg_q[CFG_RX_POL_BIT]);
   assign ask_rx_active = to_pin(ask_rx_pin, cfg_q[CFG_RX_POL_BIT]) && ask_mode;

   irpc_pulse_filter #(.MIN_CYC(RX_MIN_CYC)) u_filter (
      .clock        (clock),
      .rst          (rst),
      .clk_en       (clk_en),
      .level_active (ir_rx_active && !ask_mode),
      .detect       (ir_detect)
   );

   // Pulse encoder; the tick counter restarts on every data edge so the
   // pulse lands at the start of the bit whatever the rate
   always_comb begin
      cfg_d      = {cfg_tx_active_high, cfg_rx_active_high};
      txd_prev_d = uart_txd;
      tx_tick_d  = tx_tick_q;
      if (uart_txd != txd_prev_q) begin
         tx_tick_d = '0;
      end else if (baud_tick) begin
         tx_tick_d = (tx_tick_q == TW'(TICKS_PER_BIT - 1)) ? '0 : tx_tick_q + 1'b1;
      end
      ir_pulse_d = !ask_mode && !uart_txd && (tx_tick_d < TW'(PULSE_TICKS));
   end

   // Carrier generator; phase length is absolute, not rate-dependent
   always_comb begin
      car_cnt_d = car_cnt_q;
      car_on_d  = car_on_q;
      if (!ask_mode || uart_txd) begin
         car_cnt_d = '0;
         car_on_d  = 1'b1;
      end else if (!ask_burst_q && car_on_q) begin
         // First burst cycle counts as phase cycle 0, so the first phase is full length
         car_cnt_d = '0;
      end else if (car_cnt_q == CW'(CAR_PHASE_CYC - 1)) begin
         car_cnt_d = '0;
         car_on_d  = !car_on_q;
      end else begin
         car_cnt_d = car_cnt_q + 1'b1;
      end
      ask_burst_d = ask_mode && !uart_txd && car_on_d;
   end

   // Decoders: a detected pulse holds the line low for one bit time;
   // carrier holds it low until the carrier has been gone a while
   always_comb begin
      rx_low_d   = rx_low_q;
      ask_hold_d = ask_hold_q;
      if (ir_detect) begin
         rx_low_d = TW'(TICKS_PER_BIT);
      end else if (baud_tick && rx_low_q != '0) begin
         rx_low_d = rx_low_q - 1'b1;
      end
      if (ask_rx_active) begin
         ask_hold_d = HW'(ASK_HOLD_CYC);
      end else if (ask_hold_q != '0) begin
         ask_hold_d = ask_hold_q - 1'b1;
      end
      rxd_d    = ask_mode ? (ask_hold_d == '0) : (rx_low_d == '0);
      ir_tx_d  = to_pin(ir_pulse_d, cfg_q[CFG_TX_POL_BIT]);
      ask_tx_d = to_pin(ask_burst_d, cfg_q[CFG_TX_POL_BIT]);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         cfg_q       <= CFG_RESET;
         txd_prev_q  <= 1'b1;
         tx_tick_q   <= '0;
         ir_pulse_q  <= 1'b0;
         car_cnt_q   <= '0;
         car_on_q    <= 1'b1;
         ask_burst_q <= 1'b0;
         rx_low_q    <= '0;
         ask_hold_q  <= '0;
         rxd_q       <= 1'b1;
         ir_tx_q     <= 1'b0;
         ask_tx_q    <= 1'b0;
      end else if (clk_en) begin
         cfg_q       <= cfg_d;
         txd_prev_q  <= txd_prev_d;
         tx_tick_q   <= tx_tick_d;
         ir_pulse_q  <= ir_pulse_d;
         car_cnt_q   <= car_cnt_d;
         car_on_q    <= car_on_d;
         ask_burst_q <= ask_burst_d;
         rx_low_q    <= rx_low_d;
         ask_hold_q  <= ask_hold_d;
         rxd_q       <= rxd_d;
         ir_tx_q     <= ir_tx_d;
         ask_tx_q    <= ask_tx_d;
      end
   end

   assign uart_rxd   = rxd_q;
   assign ir_tx_pin  = ir_tx_q;
   assign ask_tx_pin = ask_tx_q;

   // Checking helpers
   logic [7:0]  a_ptick_q;
   logic [15:0] a_phase_q;
   always_ff @(posedge clock) begin
      if (rst) begin
         a_ptick_q <= '0;
         a_phase_q <= '0;
      end else if (clk_en) begin
         a_ptick_q <= !ir_pulse_q ? 8'h00 : (baud_tick ? a_ptick_q + 8'h01 : a_ptick_q);
         a_phase_q <= (ask_burst_d != ask_burst_q) ? 16'h0001 : a_phase_q + 16'h0001;
      end
   end

   sequence s_zero_start;
      !ask_mode && $fell(uart_txd);
   endsequence
   sequence s_pulse_out;
      ##1 ir_pulse_q;
   endsequence

   property p_zero_pulse;
      @(posedge clock) disable iff (rst || !clk_en)
         s_zero_start |-> s_pulse_out;
   endproperty
   a_zero_pulse: assert property (p_zero_pulse) else $error("no pulse at zero bit start");

   property p_one_quiet;
      @(posedge clock) disable iff (rst || !clk_en)
         uart_txd && $past(uart_txd) |=> !ir_pulse_q;
   endproperty
   a_one_quiet: assert property (p_one_quiet) else $error("pulse sent for a one bit");

   property p_pulse_width;
      @(posedge clock) disable iff (rst || !clk_en)
         ir_pulse_q |-> a_ptick_q < 8'(PULSE_TICKS);
   endproperty
   a_pulse_width: assert property (p_pulse_width) else $error("pulse longer than 3 ticks");

   property p_tx_pol;
      @(posedge clock) disable iff (rst || !clk_en)
         ir_tx_q == (ir_pulse_q == $past(cfg_q[CFG_TX_POL_BIT]));
   endproperty
   a_tx_pol: assert property (p_tx_pol) else $error("transmit pin polarity wrong");

   property p_rx_decode;
      @(posedge clock) disable iff (rst || !clk_en)
         ir_detect && !ask_mode |=> !rxd_q;
   endproperty
   a_rx_decode: assert property (p_rx_decode) else $error("detected pulse not decoded");

   property p_rx_pol;
      @(posedge clock) disable iff (rst || !clk_en)
         !ask_mode && (ir_rx_pin != cfg_q[CFG_RX_POL_BIT]) |=> !ir_detect;
   endproperty
   a_rx_pol: assert property (p_rx_pol) else $error("inactive pin level detected");

   property p_carrier_phase;
      @(posedge clock) disable iff (rst || !clk_en)
         ask_mode && $past(ask_mode) && !uart_txd && !$past(uart_txd)
         && ask_burst_d != ask_burst_q && $past(ask_burst_d) == $past(ask_burst_q)
         |-> a_phase_q == 16'(CAR_PHASE_CYC);
   endproperty
   a_carrier_phase: assert property (p_carrier_phase) else $error("carrier phase not 1 us");

   property p_ask_rx;
      @(posedge clock) disable iff (rst || !clk_en)
         ask_mode && (ask_rx_pin == cfg_q[CFG_RX_POL_BIT]) |=> !rxd_q;
   endproperty
   a_ask_rx: assert property (p_ask_rx) else $error("carrier not decoded");

   property p_ask_tx;
      @(posedge clock) disable iff (rst || !clk_en)
         ask_mode && $fell(uart_txd) |=> ask_tx_q == cfg_q[CFG_TX_POL_BIT];
   endproperty
   a_ask_tx: assert property (p_ask_tx) else $error("burst does not start on");
endmodule
`default_nettype wire

/* testbench/irpc_xcvr_model.sv */
`default_nettype none
module irpc_xcvr_model (
   input  wire logic clock,
   input  wire logic rx_active_high,
   output wire logic ir_rx_pin,
   output wire logic ask_rx_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ir_on  = 1'b0;
   logic ask_on = 1'b0;
   // Dark optics show the idle level of the chosen polarity
   assign ir_rx_pin  = ir_on ~^ rx_active_high;
   assign ask_rx_pin = ask_on ~^ rx_active_high;
   task automatic flash(input int cycles);
      @(negedge clock);
      ir_on = 1'b1;
      repeat (cycles) @(negedge clock);
      ir_on = 1'b0;
   endtask
   // Carrier phases of 125 cycles, first phase lit
   task automatic burst(input int phases);
      repeat (phases) begin
         @(negedge clock);
         ask_on = ~ask_on;
         repeat (124) @(negedge clock);
      end
      ask_on = 1'b0;
   endtask
endmodule
`default_nettype wire

/* testbench/testbench.sv */
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, rst, clk_en, baud_tick, ask_mode, cfg_rx, cfg_tx, uart_txd;
   wire  uart_rxd, ir_rx_pin, ir_tx_pin, ask_rx_pin, ask_tx_pin;
   int   mismatches = 0;
   int   n_compared = 0;
   int   tick_div   = 68;
   int   tick_cnt   = 0;
   int   unsigned seed = 24;
   int   divs [7]   = '{68, 136, 203, 407, 814, 1628, 3255};
   int   max_ns [7] = '{2710, 3690, 5530, 11070, 22130, 44270, 88550};

   irpc_codec u_dut (
      .clock(clock), .rst(rst), .clk_en(clk_en), .baud_tick(baud_tick),
      .ask_mode(ask_mode), .cfg_rx_active_high(cfg_rx), .cfg_tx_active_high(cfg_tx),
      .uart_txd(uart_txd), .uart_rxd(uart_rxd), .ir_rx_pin(ir_rx_pin),
      .ir_tx_pin(ir_tx_pin), .ask_rx_pin(ask_rx_pin), .ask_tx_pin(ask_tx_pin));
   irpc_xcvr_model u_xcvr (
      .clock(clock), .rx_active_high(cfg_rx), .ir_rx_pin(ir_rx_pin),
      .ask_rx_pin(ask_rx_pin));

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // Sixteen ticks per bit; divider set per baud rate
   always @(negedge clock) begin
      tick_cnt  <= (tick_cnt >= tick_div - 1) ? 0 : tick_cnt + 1;
      baud_tick <= (tick_cnt >= tick_div - 1);
   end

   function automatic int unsigned xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic pin(input int sel);
      return (sel == 0) ? ir_tx_pin : (sel == 1) ? ask_tx_pin : uart_rxd;
   endfunction
   // Cycles until the output reaches act, then cycles it stays there
   task automatic measure(input int sel, input logic act, input int lim,
                          output int lat, output int len);
      lat = 0;
      len = 0;
      while (pin(sel) !== act && lat < lim) begin
         @(negedge clock);
         lat++;
      end
      while (pin(sel) === act && len < 4 * lim) begin
         @(negedge clock);
         len++;
      end
   endtask
   // Data changes ride on a reference tick, as the character engine shifts on one
   task automatic on_tick();
      do @(negedge clock); while (tick_cnt != tick_div - 1);
   endtask
   task automatic check(input bit ok, input string what);
      n_compared++;
      if (!ok) begin
         mismatches++;
         $display("unexpected at %0t ns: %s", $time, what);
      end
   endtask
   task automatic summarize();
      if (mismatches == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      repeat (100000) @(posedge clock);
      mismatches++;
      summarize();
   end

   initial begin
      int lat, len, per, w;
      rst = 1'b1;
      clk_en = 1'b1;
      ask_mode = 1'b0;
      cfg_rx = 1'b0;
      cfg_tx = 1'b1;
      uart_txd = 1'b1;
      repeat (20) @(negedge clock);
      rst = 1'b0;
      for (int r = 0; r < 7; r++) begin
         tick_div = divs[r];
         cfg_tx = r[0];
         cfg_rx = r[1];
         repeat (4) @(negedge clock);
         check(ir_tx_pin === ~cfg_tx && ask_tx_pin === ~cfg_tx, "tx idle");
         check(uart_rxd === 1'b1, "rx idle");
         on_tick();
         uart_txd = 1'b0;
         measure(0, cfg_tx, 4 * tick_div, lat, w);
         check(lat <= 2 && w >= 177 && w * 8 <= max_ns[r], "pulse width");
         if (r == 0) begin
            measure(0, cfg_tx, 2000, per, len);
            check(w + per >= 16 * 68 - 2 && w + per <= 16 * 68 + 2, "bit period");
         end
         uart_txd = 1'b1;
         if (r == 0) begin
            measure(0, cfg_tx, 1200, lat, len);
            check(len == 0, "pulse on one bit");
         end
      end
      tick_div = 68;
      for (int i = 0; i < 11; i++) begin
         w = (i < 3) ? 176 + i : 140 + int'(xs() % 80);
         cfg_rx = 1'(xs());
         repeat (4) @(negedge clock);
         fork
            u_xcvr.flash(w);
            measure(2, 1'b0, 400, lat, len);
         join
         check((len > 0) == (w >= 177), "pulse filter");
         if (w >= 177) check(len >= 15 * 68 && len <= 17 * 68, "rx zero bit");
      end
      ask_mode = 1'b1;
      cfg_tx = 1'b1;
      repeat (4) @(negedge clock);
      uart_txd = 1'b0;
      measure(1, 1'b1, 200, lat, len);
      check(lat <= 2 && len >= 100 && len <= 150, "carrier on");
      measure(1, 1'b0, 200, lat, len);
      check(lat == 0 && len >= 100 && len <= 150, "carrier off");
      check(ir_tx_pin === 1'b0, "pulse pin in ask");
      uart_txd = 1'b1;
      repeat (300) @(negedge clock);
      fork
         u_xcvr.burst(4);
         measure(2, 1'b0, 300, lat, len);
      join
      check(lat <= 3 && len >= 700 && len <= 1000, "carrier detect");
      // Enable low mid-phase must stretch the phase by exactly the frozen span
      uart_txd = 1'b0;
      repeat (10) @(negedge clock);
      clk_en = 1'b0;
      repeat (200) @(negedge clock);
      check(ask_tx_pin === 1'b1, "carrier frozen");
      clk_en = 1'b1;
      measure(1, 1'b1, 200, lat, len);
      check(lat == 0 && len == 116, "phase after freeze");
      summarize();
   end
endmodule
`default_nettype wire
